// file: hw/dtb_dev.sv
// Comparators, trigger and break controller and the eight-word trace store.
// Assumes the core end drives the bus view and register strobes on clk.
`timescale 1ns/10ps
`default_nettype none
module dtb_dev (
  input wire logic clk,
  input wire logic reset,
  dtb_if.dev b,
  output logic run_active,
  output logic [3:0] trace_count
);
  typedef struct packed {
    logic [7:0] ax, ah, al, bx, bh, bl, cx, ch, cl, ctrl, trig;
    logic run_active_status;
    logic [2:0] flags;
    logic [3:0] cnt;
    logic [2:0] wptr;
    logic a_seen, trg_done, pend_a, pend_b;
    logic [16:0] prev_addr;
    logic brk_force, brk_tag;
    logic [7:0] rdata;
    logic [7:0][17:0] mem;
  } dtb_dev_s;

  dtb_dev_s s_ff, nxt_s;

  function automatic logic [16:0] cat_addr(input logic [7:0] x, input logic [7:0] h,
                                           input logic [7:0] l);
    cat_addr = {x[dtb_pkg::X_A16], h, l};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0] mode;
    logic evo, full, beg, en, brk, wr_sel, rw_ok, rw_a, rw_b, dedup, qs;
    logic [7:0] dbus;
    logic [16:0] adr_a, adr_b, adr_c, cof_addr;
    logic ma, mb, mbd, hc, exa, exb, qa, qb, ha, hb, trig, ev, dup, store, disarm, arming;
    logic [17:0] entry;
    nxt_s = s_ff;
    nxt_s.brk_force = 1'b0;
    nxt_s.brk_tag = 1'b0;
    mode = s_ff.trig[3:0];
    evo = mode == dtb_pkg::MODE_EV_B || mode == dtb_pkg::MODE_A_THEN_EV_B;
    full = mode == dtb_pkg::MODE_A_AND_B || mode == dtb_pkg::MODE_A_NOT_B;
    // event modes act as begin runs
    beg = s_ff.trig[dtb_pkg::T_BEGIN] | evo;
    en = s_ff.ctrl[dtb_pkg::C_EN];
    brk = s_ff.ctrl[dtb_pkg::C_BRK];
    dedup = s_ff.trig[dtb_pkg::T_DEDUP];
    adr_a = cat_addr(s_ff.ax, s_ff.ah, s_ff.al);
    adr_b = cat_addr(s_ff.bx, s_ff.bh, s_ff.bl);
    adr_c = cat_addr(s_ff.cx, s_ff.ch, s_ff.cl);
    // full modes use first direction bits
    wr_sel = s_ff.ctrl[dtb_pkg::C_DIR_MATCH_ENABLE] & ~s_ff.ctrl[dtb_pkg::C_RWA];
    dbus = wr_sel ? b.core_wdata : b.core_rdata;
    rw_ok = wr_sel ? ~b.core_rw : b.core_rw;
    rw_a = ~s_ff.ctrl[dtb_pkg::C_DIR_MATCH_ENABLE] | (b.core_rw == s_ff.ctrl[dtb_pkg::C_RWA]);
    rw_b = ~s_ff.ctrl[dtb_pkg::C_SECOND_DIR_ENABLE] | (b.core_rw == s_ff.ctrl[dtb_pkg::C_RWB]);
    ma = b.core_valid && b.core_addr == adr_a && (full ? rw_ok : rw_a);
    // second comparator on data in full modes
    mbd = b.core_valid && rw_ok && dbus == s_ff.bl;
    mb = full ? mbd : (b.core_valid && b.core_addr == adr_b && rw_b);
    hc = b.core_valid && b.core_addr == adr_c && !dedup;
    qs = s_ff.trig[dtb_pkg::T_SEL] & ~evo;
    exa = b.core_exec && b.core_exec_addr == adr_a;
    exb = b.core_exec && b.core_exec_addr == adr_b;
    qa = qs ? (s_ff.pend_a | ma) & exa : ma;
    qb = (qs && !full) ? (s_ff.pend_b | mb) & exb : mb;
    nxt_s.pend_a = qs & (s_ff.pend_a | ma) & ~exa;
    nxt_s.pend_b = qs & (s_ff.pend_b | mb) & ~exb;
    ha = 1'b0;
    hb = 1'b0;
    trig = 1'b0;
    case (mode)
      dtb_pkg::MODE_A_ONLY: begin
        ha = qa;
        trig = qa;
      end
      dtb_pkg::MODE_A_OR_B: begin
        ha = qa;
        hb = qb;
        trig = qa | qb;
      end
      dtb_pkg::MODE_A_THEN_B, dtb_pkg::MODE_A_THEN_EV_B: begin
        ha = qa;
        hb = qb & s_ff.a_seen;
        trig = hb;
      end
      dtb_pkg::MODE_EV_B: begin
        hb = qb;
        trig = qb;
      end
      dtb_pkg::MODE_A_AND_B: begin
        ha = qa & mbd;
        hb = ha;
        trig = ha;
      end
      dtb_pkg::MODE_A_NOT_B: begin
        ha = qa & ~mbd;
        hb = ha;
        trig = ha;
      end
      dtb_pkg::MODE_INSIDE: begin
        ha = b.core_valid && b.core_addr >= adr_a && b.core_addr <= adr_b;
        hb = ha;
        trig = ha;
      end
      dtb_pkg::MODE_OUTSIDE: begin
        ha = b.core_valid && b.core_addr < adr_a;
        hb = b.core_valid && b.core_addr > adr_b;
        trig = ha | hb;
      end
      default: trig = 1'b0;
    endcase
    if (!s_ff.run_active_status) begin
      ha = 1'b0;
      hb = 1'b0;
      trig = 1'b0;
    end
    if (s_ff.run_active_status && qa)
      nxt_s.a_seen = 1'b1;
    nxt_s.flags = s_ff.flags | {ha, hb, hc & en};
    cof_addr = b.core_cof[1] ? b.core_addr : 17'(s_ff.prev_addr - dtb_pkg::COF_BACKSTEP);
    entry = evo ? {10'h000, dbus} : {b.core_paged_access_ind, cof_addr};
    ev = evo ? hb : (b.core_valid && |b.core_cof);
    if (b.core_valid)
      nxt_s.prev_addr = b.core_addr;
    // suppress repeat of last stored flow
    dup = dedup && !evo && entry == {s_ff.cx[dtb_pkg::X_PAG], adr_c};
    // end runs store up to trigger only; begin runs after it
    store = s_ff.run_active_status && ev && !dup && (beg ? (s_ff.trg_done | trig) : 1'b1);
    disarm = 1'b0;
    if (store) begin
      nxt_s.mem[s_ff.wptr] = entry;
      nxt_s.wptr = s_ff.wptr + 3'h1;
      if (s_ff.cnt != dtb_pkg::CNT_FULL)
        nxt_s.cnt = s_ff.cnt + 4'h1;
      if (dedup && !evo) begin
        nxt_s.cx = {b.core_paged_access_ind, 6'h00, entry[16]};
        nxt_s.ch = entry[15:8];
        nxt_s.cl = entry[7:0];
      end
    end
    if (trig)
      nxt_s.trg_done = 1'b1;
    // break at full in begin runs, at trigger in end runs
    if (beg && store && s_ff.cnt == dtb_pkg::CNT_FULL - 4'h1)
      disarm = 1'b1;
    if (!beg && trig)
      disarm = 1'b1;
    if (brk && en && (disarm || hc)) begin
      nxt_s.brk_tag = s_ff.ctrl[dtb_pkg::C_TAG];
      nxt_s.brk_force = ~s_ff.ctrl[dtb_pkg::C_TAG];
    end
    if (disarm)
      nxt_s.ctrl[dtb_pkg::C_ARM] = 1'b0;
    arming = 1'b0;
    if (b.reg_wr) begin
      case (b.reg_addr)
        dtb_pkg::OFF_AX: nxt_s.ax = b.reg_wdata;
        dtb_pkg::OFF_AH: nxt_s.ah = b.reg_wdata;
        dtb_pkg::OFF_AL: nxt_s.al = b.reg_wdata;
        dtb_pkg::OFF_BX: nxt_s.bx = b.reg_wdata;
        dtb_pkg::OFF_BH: nxt_s.bh = b.reg_wdata;
        dtb_pkg::OFF_BL: nxt_s.bl = b.reg_wdata;
        dtb_pkg::OFF_CX: nxt_s.cx = b.reg_wdata;
        dtb_pkg::OFF_CH: nxt_s.ch = b.reg_wdata;
        dtb_pkg::OFF_CL: nxt_s.cl = b.reg_wdata;
        dtb_pkg::OFF_CTRL: begin
          nxt_s.ctrl = b.reg_wdata;
          arming = b.reg_wdata[dtb_pkg::C_EN] & b.reg_wdata[dtb_pkg::C_ARM] & ~s_ff.run_active_status;
        end
        // Trigger setup is frozen while a run is armed
        dtb_pkg::OFF_TRIG: if (!s_ff.ctrl[dtb_pkg::C_ARM]) nxt_s.trig = b.reg_wdata;
        default: ;
      endcase
    end
    if (arming) begin
      // arming clears flags and run state
      nxt_s.flags = 3'h0;
      nxt_s.cnt = 4'h0;
      nxt_s.wptr = 3'h0;
      nxt_s.a_seen = 1'b0;
      nxt_s.trg_done = 1'b0;
      nxt_s.pend_a = 1'b0;
      nxt_s.pend_b = 1'b0;
      if (nxt_s.trig[dtb_pkg::T_DEDUP]) begin
        nxt_s.cx = dtb_pkg::RST_REG;
        nxt_s.ch = dtb_pkg::RST_REG;
        nxt_s.cl = dtb_pkg::RST_REG;
      end
    end
    // run active needs enable and run bit; zero write or disable clears
    nxt_s.run_active_status = nxt_s.ctrl[dtb_pkg::C_EN] & nxt_s.ctrl[dtb_pkg::C_ARM];
    if (b.reg_rd) begin
      case (b.reg_addr)
        dtb_pkg::OFF_AX: nxt_s.rdata = s_ff.ax;
        dtb_pkg::OFF_AH: nxt_s.rdata = s_ff.ah;
        dtb_pkg::OFF_AL: nxt_s.rdata = s_ff.al;
        dtb_pkg::OFF_BX: nxt_s.rdata = s_ff.bx;
        dtb_pkg::OFF_BH: nxt_s.rdata = s_ff.bh;
        dtb_pkg::OFF_BL: nxt_s.rdata = s_ff.bl;
        dtb_pkg::OFF_CX: nxt_s.rdata = s_ff.cx;
        dtb_pkg::OFF_CH: nxt_s.rdata = s_ff.ch;
        dtb_pkg::OFF_CL: nxt_s.rdata = s_ff.cl;
        dtb_pkg::OFF_CTRL: nxt_s.rdata = s_ff.ctrl;
        dtb_pkg::OFF_TRIG: nxt_s.rdata = s_ff.trig;
        dtb_pkg::OFF_STAT: nxt_s.rdata = {s_ff.flags, 4'h0, s_ff.run_active_status};
        dtb_pkg::OFF_CNT: nxt_s.rdata = {4'h0, s_ff.cnt};
        default: nxt_s.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // any reset ends the run in progress
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign b.reg_rdata = s_ff.rdata;
  assign b.brk_force = s_ff.brk_force;
  assign b.brk_tag = s_ff.brk_tag;
  assign run_active = s_ff.run_active_status;
  assign trace_count = s_ff.cnt;
endmodule
`default_nettype wire

// file: hw/dtb_pkg.sv
// Package for the trace, trigger and break controller and the core-side end.
// Assumes both ends share one clock and see the register map below.
package dtb_pkg;

  localparam int ADDR_W = 17;
  localparam int DEPTH = 8;
  localparam int ENTRY_W = 18;

  // Register offsets
  localparam logic [3:0] OFF_AX = 4'h0;
  localparam logic [3:0] OFF_AH = 4'h1;
  localparam logic [3:0] OFF_AL = 4'h2;
  localparam logic [3:0] OFF_BX = 4'h3;
  localparam logic [3:0] OFF_BH = 4'h4;
  localparam logic [3:0] OFF_BL = 4'h5;
  localparam logic [3:0] OFF_CX = 4'h6;
  localparam logic [3:0] OFF_CH = 4'h7;
  localparam logic [3:0] OFF_CL = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hC;
  localparam logic [3:0] OFF_TRIG = 4'hD;
  localparam logic [3:0] OFF_STAT = 4'hE;
  localparam logic [3:0] OFF_CNT = 4'hF;

  // debug_ctrl_reg fields
  localparam int C_EN = 7;
  localparam int C_ARM = 6;
  localparam int C_TAG = 5;
  localparam int C_BRK = 4;
  localparam int C_RWA = 3;
  localparam int C_DIR_MATCH_ENABLE = 2;
  localparam int C_RWB = 1;
  localparam int C_SECOND_DIR_ENABLE = 0;
  // trigger_ctrl_reg fields
  localparam int T_SEL = 7;
  localparam int T_BEGIN = 6;
  localparam int T_DEDUP = 4;
  // Extended byte fields
  localparam int X_PAG = 7;
  localparam int X_A16 = 0;

  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] HWB_TAG_VAL = 8'h81;
  localparam logic [7:0] HWB_FORCE_VAL = 8'h01;
  localparam logic [16:0] COF_BACKSTEP = 17'h00002;
  localparam logic [3:0] CNT_FULL = 4'h8;

  typedef enum logic [3:0] {
    MODE_A_ONLY = 4'h0,
    MODE_A_OR_B = 4'h1,
    MODE_A_THEN_B = 4'h2,
    MODE_EV_B = 4'h3,
    MODE_A_THEN_EV_B = 4'h4,
    MODE_A_AND_B = 4'h5,
    MODE_A_NOT_B = 4'h6,
    MODE_INSIDE = 4'h7,
    MODE_OUTSIDE = 4'h8
  } dtb_mode_e;

endpackage

// file: hw/dtb_if.sv
// Interface joining the debug controller and the core side.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface dtb_if (
  input wire logic clk
);
  logic [16:0] core_addr;
  logic [7:0] core_rdata;
  logic [7:0] core_wdata;
  logic core_rw;
  logic core_valid;
  logic [1:0] core_cof;
  logic core_paged_access_ind;
  logic core_exec;
  logic [16:0] core_exec_addr;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic brk_force;
  logic brk_tag;

  modport dev (
    input clk, core_addr, core_rdata, core_wdata, core_rw, core_valid, core_cof,
    input core_paged_access_ind, core_exec, core_exec_addr, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, brk_force, brk_tag
  );
  modport host (
    input clk, reg_rdata, brk_force, brk_tag,
    output core_addr, core_rdata, core_wdata, core_rw, core_valid, core_cof,
    output core_paged_access_ind, core_exec, core_exec_addr, reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface
`default_nettype wire

// file: hw/dtb_core.sv
// Core-side end: drives the bus view, programs the debug unit, takes breaks.
// Assumes the debug controller end samples on the same clk.
`timescale 1ns/10ps
`default_nettype none
module dtb_core (
  input wire logic clk,
  input wire logic reset,
  dtb_if.host b,
  input wire logic [16:0] bus_addr,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_rw,
  input wire logic bus_valid,
  input wire logic [1:0] bus_cof,
  input wire logic bus_paged_access_ind,
  input wire logic bus_exec,
  input wire logic [16:0] bus_exec_addr,
  input wire logic cmd_valid,
  input wire logic cmd_wr,
  input wire logic cmd_hw_break,
  input wire logic cmd_tag_kind,
  input wire logic cmd_opcode_addr,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic insn_boundary,
  input wire logic head_exec,
  input wire logic resume,
  output logic cmd_done,
  output logic cmd_refused,
  output logic [7:0] cmd_rdata,
  output logic cpu_halted
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HWB = 2'b01,
    ST_RDW = 2'b10,
    ST_RDC = 2'b11
  } dtb_core_st_e;

  typedef struct packed {
    dtb_core_st_e st;
    logic [16:0] addr, exec_addr;
    logic [7:0] rdata, wdata, trig_sh, reg_wdata, cmd_rdata;
    logic rw, valid, paged_access_ind, exec, reg_wr, reg_rd, done, refused, halted;
    logic [1:0] cof;
    logic [3:0] reg_addr;
    logic force_pend, tag_pend, hwb_tag;
  } dtb_core_s;

  dtb_core_s s_ff, nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] wv;
    nxt_s = s_ff;
    wv = cmd_wdata;
    nxt_s.addr = bus_addr;
    nxt_s.rdata = bus_rdata;
    nxt_s.wdata = bus_wdata;
    nxt_s.rw = bus_rw;
    nxt_s.valid = bus_valid;
    nxt_s.cof = bus_cof;
    nxt_s.paged_access_ind = bus_paged_access_ind;
    nxt_s.exec = bus_exec;
    nxt_s.exec_addr = bus_exec_addr;
    nxt_s.reg_wr = 1'b0;
    nxt_s.reg_rd = 1'b0;
    nxt_s.done = 1'b0;
    nxt_s.refused = 1'b0;
    unique case (s_ff.st)
      ST_IDLE: if (cmd_valid) begin
        if (cmd_hw_break && cmd_tag_kind && !cmd_opcode_addr) begin
          // tag breakpoints qualify on opcodes, need opcode address
          nxt_s.refused = 1'b1;
          nxt_s.done = 1'b1;
        end else if (cmd_hw_break) begin
          nxt_s.trig_sh = cmd_tag_kind ? dtb_pkg::HWB_TAG_VAL : dtb_pkg::HWB_FORCE_VAL;
          nxt_s.reg_wr = 1'b1;
          nxt_s.reg_addr = dtb_pkg::OFF_TRIG;
          nxt_s.reg_wdata = nxt_s.trig_sh;
          nxt_s.hwb_tag = cmd_tag_kind;
          nxt_s.st = ST_HWB;
        end else if (cmd_wr) begin
          if (cmd_addr == dtb_pkg::OFF_CTRL) begin
            // tag agrees with qualify when begin bit clear and halt enable set; tag cleared when begin bit set
            if (s_ff.trig_sh[dtb_pkg::T_BEGIN])
              wv[dtb_pkg::C_TAG] = 1'b0;
            else if (wv[dtb_pkg::C_BRK])
              wv[dtb_pkg::C_TAG] = s_ff.trig_sh[dtb_pkg::T_SEL];
          end
          // qualified arming needs an opcode address
          if (cmd_addr == dtb_pkg::OFF_CTRL && wv[dtb_pkg::C_ARM] &&
              s_ff.trig_sh[dtb_pkg::T_SEL] && !cmd_opcode_addr) begin
            nxt_s.refused = 1'b1;
          end else begin
            nxt_s.reg_wr = 1'b1;
            nxt_s.reg_addr = cmd_addr;
            nxt_s.reg_wdata = wv;
            if (cmd_addr == dtb_pkg::OFF_TRIG)
              nxt_s.trig_sh = cmd_wdata;
          end
          nxt_s.done = 1'b1;
        end else begin
          nxt_s.reg_rd = 1'b1;
          nxt_s.reg_addr = cmd_addr;
          nxt_s.st = ST_RDW;
        end
      end
      ST_HWB: begin
        // enable with halt enable and matching kind
        nxt_s.reg_wr = 1'b1;
        nxt_s.reg_addr = dtb_pkg::OFF_CTRL;
        nxt_s.reg_wdata = 8'h00;
        nxt_s.reg_wdata[dtb_pkg::C_EN] = 1'b1;
        nxt_s.reg_wdata[dtb_pkg::C_ARM] = 1'b1;
        nxt_s.reg_wdata[dtb_pkg::C_BRK] = 1'b1;
        nxt_s.reg_wdata[dtb_pkg::C_TAG] = s_ff.hwb_tag;
        nxt_s.done = 1'b1;
        nxt_s.st = ST_IDLE;
      end
      // Controller answers one cycle after it sees the strobe
      ST_RDW: nxt_s.st = ST_RDC;
      ST_RDC: begin
        nxt_s.cmd_rdata = b.reg_rdata;
        nxt_s.done = 1'b1;
        nxt_s.st = ST_IDLE;
      end
    endcase
    // force halts at boundary, tag at queue head
    if (b.brk_force)
      nxt_s.force_pend = 1'b1;
    if (b.brk_tag)
      nxt_s.tag_pend = 1'b1;
    if ((s_ff.force_pend && insn_boundary) || (s_ff.tag_pend && head_exec)) begin
      nxt_s.halted = 1'b1;
      nxt_s.force_pend = 1'b0;
      nxt_s.tag_pend = 1'b0;
    end else if (resume) begin
      nxt_s.halted = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign b.core_addr = s_ff.addr;
  assign b.core_rdata = s_ff.rdata;
  assign b.core_wdata = s_ff.wdata;
  assign b.core_rw = s_ff.rw;
  assign b.core_valid = s_ff.valid;
  assign b.core_cof = s_ff.cof;
  assign b.core_paged_access_ind = s_ff.paged_access_ind;
  assign b.core_exec = s_ff.exec;
  assign b.core_exec_addr = s_ff.exec_addr;
  assign b.reg_wr = s_ff.reg_wr;
  assign b.reg_rd = s_ff.reg_rd;
  assign b.reg_addr = s_ff.reg_addr;
  assign b.reg_wdata = s_ff.reg_wdata;
  assign cmd_done = s_ff.done;
  assign cmd_refused = s_ff.refused;
  assign cmd_rdata = s_ff.cmd_rdata;
  assign cpu_halted = s_ff.halted;
endmodule
`default_nettype wire

// file: verif/dtb_props.sv
// Checker on the link between debug controller and core end.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dtb_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic brk_force,
  input wire logic brk_tag,
  input wire logic run_active,
  input wire logic [3:0] trace_count
);
  logic [7:0] ctrl_ff;
  // Shadow of control byte; hardware disarm not mirrored, so ARM unused
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 8'h00;
    end else if (reg_wr && reg_addr == dtb_pkg::OFF_CTRL) begin
      ctrl_ff <= reg_wdata;
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence arm_wr;
    reg_wr && reg_addr == dtb_pkg::OFF_CTRL &&
      reg_wdata[dtb_pkg::C_EN] && reg_wdata[dtb_pkg::C_ARM];
  endsequence
  sequence stat_rd_off;
    !ctrl_ff[dtb_pkg::C_EN] ##1
      (!ctrl_ff[dtb_pkg::C_EN] && reg_rd && reg_addr == dtb_pkg::OFF_STAT);
  endsequence
  AST_ARM_SETS: assert property (arm_wr |-> ##[1:2] run_active)
    else $error("arming write left run flag low");
  AST_STAT_OFF: assert property (stat_rd_off |=> !reg_rdata[0])
    else $error("run status read high while unit disabled");
  AST_RUN_EN: assert property (run_active |-> ctrl_ff[dtb_pkg::C_EN])
    else $error("run flag high with unit disabled");
  AST_BRK_HALT: assert property (brk_force || brk_tag |-> $past(ctrl_ff[dtb_pkg::C_BRK]))
    else $error("break with halt enable clear");
  AST_BRK_EN: assert property (brk_force || brk_tag |-> $past(ctrl_ff[dtb_pkg::C_EN]))
    else $error("break with unit disabled");
  AST_FORCE_KIND: assert property (brk_force |-> !$past(ctrl_ff[dtb_pkg::C_TAG]))
    else $error("force break while tag kind chosen");
  AST_TAG_KIND: assert property (brk_tag |-> $past(ctrl_ff[dtb_pkg::C_TAG]))
    else $error("tag break while force kind chosen");
  AST_ONE_KIND: assert property (!(brk_force && brk_tag))
    else $error("both break kinds at once");
  AST_CNT_MAX: assert property (trace_count <= dtb_pkg::CNT_FULL)
    else $error("trace count above eight");
  AST_CNT_STEP: assert property (trace_count != $past(trace_count) |->
    trace_count == $past(trace_count) + 4'h1 || trace_count == 4'h0)
    else $error("trace count jumped");
endmodule
`default_nettype wire

// file: verif/trace_trigger_break_control_tb.sv
// Bench joining controller and core end through the link interface.
// Assumes core end forwards bus and command inputs as its notes say.
`timescale 1ns/10ps
`default_nettype none
module trace_trigger_break_control_tb;
  localparam logic [16:0] HIT = 17'h12345;
  logic clk = 1'h0, reset = 1'h1;
  logic [16:0] bus_addr = 17'h00000, bus_exec_addr = 17'h00000, seed = 17'h110B9;
  logic [7:0] bus_rdata = 8'h00, bus_wdata = 8'h00, cmd_wdata = 8'h00, cmd_rdata, rd_val;
  logic [1:0] bus_cof = 2'h0;
  logic [3:0] cmd_addr = 4'h0, trace_count;
  logic bus_rw = 1'h1, bus_valid = 1'h0, bus_paged_access_ind = 1'h0, bus_exec = 1'h0;
  logic cmd_valid = 1'h0, cmd_wr = 1'h0, cmd_hw_break = 1'h0, cmd_tag_kind = 1'h0;
  logic cmd_opcode_addr = 1'h0, insn_boundary = 1'h0, head_exec = 1'h0, resume = 1'h0;
  logic cmd_done, cmd_refused, cpu_halted, run_active, refused;
  logic [16:0] s1, s2;
  int fail_count = 0, num_checks = 0;

  always #10 clk = ~clk;
  dtb_if i_dtb_if (.clk(clk));
  dtb_dev i_dtb_dev (.clk(clk), .reset(reset), .b(i_dtb_if), .run_active(run_active),
    .trace_count(trace_count));
  dtb_core i_dtb_core (.clk(clk), .reset(reset), .b(i_dtb_if), .bus_addr(bus_addr),
    .bus_rdata(bus_rdata), .bus_wdata(bus_wdata), .bus_rw(bus_rw), .bus_valid(bus_valid),
    .bus_cof(bus_cof), .bus_paged_access_ind(bus_paged_access_ind), .bus_exec(bus_exec),
    .bus_exec_addr(bus_exec_addr), .cmd_valid(cmd_valid), .cmd_wr(cmd_wr),
    .cmd_hw_break(cmd_hw_break), .cmd_tag_kind(cmd_tag_kind),
    .cmd_opcode_addr(cmd_opcode_addr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .insn_boundary(insn_boundary), .head_exec(head_exec), .resume(resume),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused), .cmd_rdata(cmd_rdata),
    .cpu_halted(cpu_halted));
  dtb_props i_dtb_props (.clk(clk), .reset(reset), .reg_wr(i_dtb_if.reg_wr),
    .reg_rd(i_dtb_if.reg_rd), .reg_addr(i_dtb_if.reg_addr), .reg_wdata(i_dtb_if.reg_wdata),
    .reg_rdata(i_dtb_if.reg_rdata), .brk_force(i_dtb_if.brk_force),
    .brk_tag(i_dtb_if.brk_tag), .run_active(run_active), .trace_count(trace_count));
  //////////////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic logic [7:0] stat_exp(input logic f1, f2, f3, arm);
    return {f1, f2, f3, 4'h0, arm};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmd(input logic w, hw, tk, op, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_wr <= w;
    cmd_hw_break <= hw;
    cmd_tag_kind <= tk;
    cmd_opcode_addr <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'h0;
    #1;
    while (cmd_done !== 1'h1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, n < 20}, 8'h01);
    refused = cmd_refused;
    rd_val = cmd_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(1'h1, 1'h0, 1'h0, 1'h0, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    cmd(1'h0, 1'h0, 1'h0, 1'h0, a, 8'h00);
  endtask
  // Gaps between bus cycles keep each exec pulse separate
  task automatic bus_cyc(input logic [16:0] a, input logic [1:0] cof);
    @(posedge clk);
    seed = lfsr(seed);
    bus_addr <= a;
    bus_exec_addr <= a;
    bus_cof <= cof;
    bus_rdata <= seed[7:0];
    bus_wdata <= seed[15:8];
    bus_paged_access_ind <= seed[16];
    bus_valid <= 1'h1;
    bus_exec <= 1'h1;
    @(posedge clk);
    bus_valid <= 1'h0;
    bus_exec <= 1'h0;
  endtask
  task automatic traffic(input int k);
    repeat (k) begin
      bus_cyc(lfsr(seed), 2'h2);
    end
  endtask
  task automatic halt_chk(input logic exp);
    int n;
    n = 0;
    while (cpu_halted !== 1'h1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, cpu_halted}, {7'h00, exp});
    @(posedge clk);
    resume <= 1'h1;
    @(posedge clk);
    resume <= 1'h0;
  endtask
  //////////////////////////////////////////////////
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    insn_boundary <= 1'h1;
    head_exec <= 1'h1;
    wr(dtb_pkg::OFF_AX, 8'h01);
    wr(dtb_pkg::OFF_AH, 8'h23);
    wr(dtb_pkg::OFF_AL, 8'h45);
    rd(dtb_pkg::OFF_AH);
    check(rd_val, 8'h23);
    rd(4'hA);
    check(rd_val, 8'h00);
    cmd(1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 8'h00);
    check({7'h00, refused}, 8'h00);
    traffic(10);
    bus_cyc(HIT, 2'h2);
    halt_chk(1'h1);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h1, 1'h0, 1'h0, 1'h0));
    check({4'h0, trace_count}, 8'h08);
    cmd(1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 8'h00);
    check({7'h00, refused}, 8'h01);
    cmd(1'h0, 1'h1, 1'h1, 1'h1, 4'h0, 8'h00);
    check({7'h00, refused}, 8'h00);
    bus_cyc(HIT, 2'h0);
    halt_chk(1'h1);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h1, 1'h0, 1'h0, 1'h0));
    wr(dtb_pkg::OFF_TRIG, 8'h00);
    wr(dtb_pkg::OFF_CTRL, 8'hC0);
    bus_cyc(HIT, 2'h0);
    halt_chk(1'h0);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h1, 1'h0, 1'h0, 1'h0));
    for (int m = 9; m < 16; m++) begin
      wr(dtb_pkg::OFF_TRIG, {4'h0, m[3:0]});
      wr(dtb_pkg::OFF_CTRL, 8'hC0);
      bus_cyc(HIT, 2'h2);
      rd(dtb_pkg::OFF_STAT);
      check(rd_val, stat_exp(1'h0, 1'h0, 1'h0, 1'h1));
      wr(dtb_pkg::OFF_CTRL, 8'h00);
      rd(dtb_pkg::OFF_STAT);
      check(rd_val, 8'h00);
    end
    wr(dtb_pkg::OFF_TRIG, 8'h40);
    wr(dtb_pkg::OFF_CTRL, 8'hD0);
    bus_cyc(HIT, 2'h2);
    traffic(6);
    check({7'h00, cpu_halted}, 8'h00);
    traffic(5);
    halt_chk(1'h1);
    check({4'h0, trace_count}, 8'h08);
    check({7'h00, run_active}, 8'h00);
    // Sequenced mode: second address ignored until first seen
    wr(dtb_pkg::OFF_BH, 8'hAB);
    wr(dtb_pkg::OFF_BL, 8'hCD);
    wr(dtb_pkg::OFF_TRIG, 8'h02);
    wr(dtb_pkg::OFF_CTRL, 8'hC0);
    bus_cyc(17'h0ABCD, 2'h2);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h0, 1'h0, 1'h0, 1'h1));
    bus_cyc(HIT, 2'h2);
    bus_cyc(17'h0ABCD, 2'h2);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h1, 1'h1, 1'h0, 1'h0));
    // Full mode: read data must match in the address cycle
    wr(dtb_pkg::OFF_TRIG, 8'h05);
    s1 = lfsr(seed);
    wr(dtb_pkg::OFF_BL, ~s1[7:0]);
    wr(dtb_pkg::OFF_CTRL, 8'hC0);
    bus_cyc(HIT, 2'h2);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h0, 1'h0, 1'h0, 1'h1));
    s1 = lfsr(seed);
    wr(dtb_pkg::OFF_BL, s1[7:0]);
    bus_cyc(HIT, 2'h2);
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, stat_exp(1'h1, 1'h1, 1'h0, 1'h0));
    // Dedup mode: repeat of same flow entry is not stored
    wr(dtb_pkg::OFF_CL, 8'h55);
    wr(dtb_pkg::OFF_TRIG, 8'h10);
    wr(dtb_pkg::OFF_CTRL, 8'hC0);
    rd(dtb_pkg::OFF_CL);
    check(rd_val, 8'h00);
    s1 = lfsr(seed);
    s2 = lfsr(s1);
    bus_cyc(17'h1F00E, 2'h2);
    bus_cyc(17'h1F00E, 2'h2);
    rd(dtb_pkg::OFF_CX);
    check(rd_val, {s2[16], 6'h00, 1'h1});
    check({4'h0, trace_count}, {6'h00, s1[16] != s2[16], s1[16] == s2[16]});
    rd(dtb_pkg::OFF_CL);
    check(rd_val, 8'h0E);
    wr(dtb_pkg::OFF_CTRL, 8'h00);
    wr(dtb_pkg::OFF_TRIG, 8'h00);
    wr(dtb_pkg::OFF_CTRL, 8'hC0);
    // Controller takes the write one edge after the command completes
    @(posedge clk);
    #1;
    check({7'h00, run_active}, 8'h01);
    @(posedge clk);
    reset <= 1'h1;
    #1;
    check({7'h00, run_active}, 8'h00);
    @(posedge clk);
    reset <= 1'h0;
    rd(dtb_pkg::OFF_STAT);
    check(rd_val, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
